// ==== hw/rtcp_map.svh ====
// Constants of the two-wire slave port: address, bit counts, resets, rates.
// Assumes it is included by its bare name from the package, sampler and slave files.
`ifndef RTCP_MAP_SVH
`define RTCP_MAP_SVH

// Own 7-bit slave address
`define RTCP_SLAVE_ADDR   7'h68
// Direction bit value for a read
`define RTCP_DIR_READ     1'b1
// Bits per byte and width of the bit counter
`define RTCP_BYTE_BITS    4'h8
`define RTCP_CNT_W        4
// Register pointer width and its value after reset
`define RTCP_PTR_W        8
`define RTCP_PTR_RST      8'h00
// Pulled level of the open-drain data line
`define RTCP_SDA_LOW      1'b0
// Sampling stages on each pin input
`define RTCP_SYNC_STAGES  3
// Core rate and the standard and fastest serial clock rates served
`define RTCP_CORE_HZ      20000000
`define RTCP_SCL_STD_HZ   100000
`define RTCP_SCL_FAST_HZ  400000
// Core cycles in one fast-mode serial clock period
`define RTCP_CYC_PER_SCL  (`RTCP_CORE_HZ / `RTCP_SCL_FAST_HZ)

`endif

// ==== hw/rtcp_pkg.sv ====
// Types shared by the slave port modules: states and module state records.
// Assumes rtcp_map.svh for widths.
`include "rtcp_map.svh"

package rtcp_pkg;

  typedef enum logic [9:0] {
    RTCP_IDLE     = 10'b0000000001,
    RTCP_ADDR     = 10'b0000000010,
    RTCP_ADDR_ACK = 10'b0000000100,
    RTCP_PTR      = 10'b0000001000,
    RTCP_PTR_ACK  = 10'b0000010000,
    RTCP_WDATA    = 10'b0000100000,
    RTCP_WACK     = 10'b0001000000,
    RTCP_RDATA    = 10'b0010000000,
    RTCP_RACK     = 10'b0100000000,
    RTCP_IGNORE   = 10'b1000000000
  } rtcp_state_type;

  typedef logic [`RTCP_PTR_W-1:0] rtcp_byte_type;

  typedef struct packed {
    logic [1:0] s1;
    logic [1:0] s2;
    logic [1:0] s3;
    logic [1:0] lvl;
  } rtcp_sync_st_type;

  typedef struct packed {
    logic scl_d;
    logic sda_d;
  } rtcp_cond_st_type;

  typedef struct packed {
    rtcp_state_type          state;
    logic [`RTCP_CNT_W-1:0]  cnt;
    rtcp_byte_type           sh;
    rtcp_byte_type           ptr;
    logic                    dir_rd;
    logic                    nack;
    logic                    sda_oe;
    logic                    sda_out;
    logic                    wr_stb;
    rtcp_byte_type           wr_addr;
    rtcp_byte_type           wr_data;
    logic                    rd_stb;
    logic                    busy;
    logic                    selected;
  } rtcp_core_st_type;

endpackage

// ==== hw/rtcp_line_if.sv ====
// Sampled bus line levels and the events found on them.
// Assumes one core clock drives every party.
`timescale 1ns/10ps

interface rtcp_line_if;
  logic scl;
  logic sda;
  logic scl_rise;
  logic scl_fall;
  logic start_det;
  logic stop_det;

  modport sync (output scl, output sda);
  modport cond (input scl, input sda, output scl_rise, output scl_fall,
                output start_det, output stop_det);
  modport core (input scl, input sda, input scl_rise, input scl_fall,
                input start_det, input stop_det);
endinterface

// ==== hw/rtcp_sync.sv ====
// Three-stage pin sampler for the serial clock and data lines.
// Assumes both pins are asynchronous to core_clk.
`timescale 1ns/10ps
`include "rtcp_map.svh"

module rtcp_sync (
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  // Raw pins
  input  wire logic  scl_pin,
  input  wire logic  sda_pin,
  // Filtered levels
  rtcp_line_if.sync  line
);
  import rtcp_pkg::*;

  rtcp_sync_st_type r_reg;
  rtcp_sync_st_type r_next;

  // Level moves only once stages two and three agree; stage one feeds stage two alone
  always_comb begin
    r_next    = r_reg;
    r_next.s1 = {sda_pin, scl_pin};
    r_next.s2 = r_reg.s1;
    r_next.s3 = r_reg.s2;
    for (int i = 0; i < 2; i++) begin
      if (r_reg.s2[i] == r_reg.s3[i]) begin
        r_next.lvl[i] = r_reg.s3[i];
      end
    end
  end

  // Idle bus reads high on both lines
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign line.scl = r_reg.lvl[0];
  assign line.sda = r_reg.lvl[1];
endmodule

// ==== hw/rtcp_cond.sv ====
// Edge and bus condition detector on the filtered lines.
// Assumes levels from rtcp_sync on the same clock.
`timescale 1ns/10ps

module rtcp_cond (
  // Clock and reset
  input  wire logic  core_clk,
  input  wire logic  sys_rst,
  // Lines and events
  rtcp_line_if.cond  line
);
  import rtcp_pkg::*;

  rtcp_cond_st_type r_reg;
  rtcp_cond_st_type r_next;

  always_comb begin
    r_next       = r_reg;
    r_next.scl_d = line.scl;
    r_next.sda_d = line.sda;
  end

  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg <= '1;
    end else begin
      r_reg <= r_next;
    end
  end

  assign line.scl_rise  = line.scl & ~r_reg.scl_d;
  assign line.scl_fall  = ~line.scl & r_reg.scl_d;
  assign line.start_det = line.scl & r_reg.scl_d & r_reg.sda_d & ~line.sda;
  assign line.stop_det  = line.scl & r_reg.scl_d & ~r_reg.sda_d & line.sda;
endmodule

// ==== hw/rtcp_slave.sv ====
// Two-wire slave port of the clock: address match, pointer, byte transfer.
// Assumes a register file outside that reads rd_addr combinationally and
// takes one-cycle write strobes; the bus pins are open drain.
// Notes on behaviour
// - Slave only: serial clock never driven, no start or stop made.
// - Works at 100 kHz and 400 kHz serial clock rates.
// - Data stable while clock high; changes then are bus conditions.
// - Data falling with clock high is a start.
// - Data rising with clock high is a stop.
// - One clock pulse per bit; change while low, sample while high.
// - Eight-bit bytes plus ninth acknowledge bit; byte count unlimited.
// - Acknowledge holds data low through the whole ninth clock high.
// - Master not-acknowledge ends read; device releases data high.
// - All bytes travel most significant bit first.
// - Repeated start begins a new transfer expecting an address.
// - First byte is address 1101000 plus direction, 1 means read.
// - Matching address byte is acknowledged.
// - First written byte loads the register pointer.
// - Further written bytes acknowledged, stored at pointer, pointer bumped.
// - Read sends bytes starting from the current pointer.
// - Read without pointer load starts at the pointer left before.
// - Bytes keep coming while master acknowledges.
`timescale 1ns/10ps
`include "rtcp_map.svh"

module rtcp_slave (
  // Clock and reset
  input  wire logic                    core_clk,
  input  wire logic                    sys_rst,
  // Serial clock pin, input only
  input  wire logic                    scl_in,
  // Serial data pin, open drain
  input  wire logic                    sda_in,
  output logic                         sda_out,
  output logic                         sda_oe,
  // Register file write side
  output logic                         wr_stb,
  output rtcp_pkg::rtcp_byte_type      wr_addr,
  output rtcp_pkg::rtcp_byte_type      wr_data,
  // Register file read side
  output rtcp_pkg::rtcp_byte_type      rd_addr,
  input  wire rtcp_pkg::rtcp_byte_type rd_data,
  output logic                         rd_stb,
  // Status
  output logic                         busy,
  output logic                         selected
);
  import rtcp_pkg::*;

  rtcp_line_if line ();

  rtcp_core_st_type r_reg;
  rtcp_core_st_type r_next;

  // Sampling margin: fifty core cycles per fast serial period
  rtcp_sync u_sync (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .scl_pin  (scl_in),
    .sda_pin  (sda_in),
    .line     (line.sync)
  );

  rtcp_cond u_cond (
    .core_clk (core_clk),
    .sys_rst  (sys_rst),
    .line     (line.cond)
  );

  // Byte count reached on the clock edge that just went by
  logic byte_done;
  assign byte_done = (r_reg.cnt == `RTCP_BYTE_BITS);

  always_comb begin
    r_next        = r_reg;
    r_next.wr_stb = 1'b0;
    r_next.rd_stb = 1'b0;

    if (line.start_det) begin
      r_next.state    = RTCP_ADDR;
      r_next.cnt      = '0;
      r_next.sda_oe   = 1'b0;
      r_next.busy     = 1'b1;
      r_next.selected = 1'b0;
      r_next.nack     = 1'b0;
    end else if (line.stop_det) begin
      r_next.state    = RTCP_IDLE;
      r_next.cnt      = '0;
      r_next.sda_oe   = 1'b0;
      r_next.busy     = 1'b0;
      r_next.selected = 1'b0;
    end else begin
      case (r_reg.state)
        RTCP_IDLE: begin
          r_next.sda_oe = 1'b0;
        end

        RTCP_ADDR: begin
          if (line.scl_rise) begin
            r_next.sh  = {r_reg.sh[6:0], line.sda};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (line.scl_fall && byte_done) begin
            r_next.cnt = '0;
            if (r_reg.sh[7:1] == `RTCP_SLAVE_ADDR) begin
              r_next.state    = RTCP_ADDR_ACK;
              r_next.dir_rd   = (r_reg.sh[0] == `RTCP_DIR_READ);
              r_next.sda_oe   = 1'b1;
              r_next.selected = 1'b1;
            end else begin
              r_next.state = RTCP_IGNORE;
            end
          end
        end

        RTCP_ADDR_ACK: begin
          if (line.scl_fall) begin
            if (r_reg.dir_rd) begin
              r_next.state  = RTCP_RDATA;
              r_next.sh     = rd_data;
              r_next.sda_oe = ~rd_data[7];
              r_next.rd_stb = 1'b1;
              r_next.cnt    = '0;
            end else begin
              r_next.state  = RTCP_PTR;
              r_next.sda_oe = 1'b0;
            end
          end
        end

        RTCP_PTR: begin
          if (line.scl_rise) begin
            r_next.sh  = {r_reg.sh[6:0], line.sda};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (line.scl_fall && byte_done) begin
            r_next.cnt    = '0;
            r_next.state  = RTCP_PTR_ACK;
            r_next.sda_oe = 1'b1;
          end
        end

        RTCP_PTR_ACK: begin
          if (line.scl_fall) begin
            r_next.ptr    = r_reg.sh;
            r_next.state  = RTCP_WDATA;
            r_next.sda_oe = 1'b0;
          end
        end

        RTCP_WDATA: begin
          if (line.scl_rise) begin
            r_next.sh  = {r_reg.sh[6:0], line.sda};
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (line.scl_fall && byte_done) begin
            r_next.cnt     = '0;
            r_next.state   = RTCP_WACK;
            r_next.sda_oe  = 1'b1;
            r_next.wr_stb  = 1'b1;
            r_next.wr_addr = r_reg.ptr;
            r_next.wr_data = r_reg.sh;
            r_next.ptr     = r_reg.ptr + 8'h01;
          end
        end

        RTCP_WACK: begin
          if (line.scl_fall) begin
            r_next.state  = RTCP_WDATA;
            r_next.sda_oe = 1'b0;
          end
        end

        RTCP_RDATA: begin
          // Count bits as the master samples them
          if (line.scl_rise) begin
            r_next.cnt = r_reg.cnt + 4'h1;
          end else if (line.scl_fall) begin
            if (byte_done) begin
              r_next.state  = RTCP_RACK;
              r_next.sda_oe = 1'b0;
              r_next.ptr    = r_reg.ptr + 8'h01;
              r_next.cnt    = '0;
            end else begin
              r_next.sh     = {r_reg.sh[6:0], 1'b0};
              r_next.sda_oe = ~r_reg.sh[6];
            end
          end
        end

        RTCP_RACK: begin
          if (line.scl_rise) begin
            r_next.nack = line.sda;
          end else if (line.scl_fall) begin
            if (r_reg.nack) begin
              r_next.state  = RTCP_IGNORE;
              r_next.sda_oe = 1'b0;
            end else begin
              r_next.state  = RTCP_RDATA;
              r_next.sh     = rd_data;
              r_next.sda_oe = ~rd_data[7];
              r_next.rd_stb = 1'b1;
              r_next.cnt    = '0;
            end
          end
        end

        RTCP_IGNORE: begin
          r_next.sda_oe = 1'b0;
        end

        default: begin
          r_next.state  = RTCP_IDLE;
          r_next.sda_oe = 1'b0;
        end
      endcase
    end
  end

  // Pointer survives transfers; only reset clears it
  always_ff @(posedge core_clk) begin
    if (sys_rst) begin
      r_reg          <= '0;
      r_reg.state    <= RTCP_IDLE;
      r_reg.ptr      <= `RTCP_PTR_RST;
      r_reg.sda_out  <= `RTCP_SDA_LOW;
    end else begin
      r_reg <= r_next;
    end
  end

  assign sda_out  = r_reg.sda_out;
  assign sda_oe   = r_reg.sda_oe;
  assign wr_stb   = r_reg.wr_stb;
  assign wr_addr  = r_reg.wr_addr;
  assign wr_data  = r_reg.wr_data;
  assign rd_addr  = r_reg.ptr;
  assign rd_stb   = r_reg.rd_stb;
  assign busy     = r_reg.busy;
  assign selected = r_reg.selected;
endmodule

// ==== tb/rtcp_slave_properties.sv ====
// Checker of the slave port pins: open-drain use, bit timing, strobes.
// Assumes it is bound to rtcp_slave and sees only its ports.
`timescale 1ns/10ps

module rtcp_slave_chk (
  // Clock and reset
  input wire logic                    core_clk,
  input wire logic                    sys_rst,
  // Bus pins
  input wire logic                    scl_in,
  input wire logic                    sda_in,
  input wire logic                    sda_out,
  input wire logic                    sda_oe,
  // Register file side
  input wire logic                    wr_stb,
  input wire rtcp_pkg::rtcp_byte_type wr_addr,
  input wire rtcp_pkg::rtcp_byte_type wr_data,
  input wire rtcp_pkg::rtcp_byte_type rd_addr,
  input wire rtcp_pkg::rtcp_byte_type rd_data,
  input wire logic                    rd_stb,
  // Status
  input wire logic                    busy,
  input wire logic                    selected
);
  import rtcp_pkg::*;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (sys_rst);

  pull_low_only_a:
    assert property (sda_oe |-> !sda_out) else $error("Data pin driven high");
  oe_steady_high_a:
    assert property (scl_in && $past(scl_in) |-> $stable(sda_oe))
      else $error("Data drive changed while clock high");
  idle_no_pull_a:
    assert property (!busy && !$past(busy) |-> !sda_oe) else $error("Pull while idle");
  start_sets_busy_a:
    assert property ($fell(sda_in) && scl_in |-> ##[1:10] busy)
      else $error("Start not seen");
  stop_clears_busy_a:
    assert property ($rose(sda_in) && scl_in |-> ##[1:10] !busy)
      else $error("Stop not seen");
  wr_one_cycle_a:
    assert property (wr_stb |=> !wr_stb) else $error("Write strobe too long");
  wr_ptr_step_a:
    assert property (wr_stb |-> ##[0:1] rd_addr == wr_addr + 8'h01)
      else $error("Pointer not advanced after write");
  rd_one_cycle_a:
    assert property (rd_stb |=> !rd_stb) else $error("Read strobe too long");
  rd_msb_first_a:
    assert property (rd_stb |-> sda_oe == !rd_data[7])
      else $error("First read bit is not the top bit");
endmodule

bind rtcp_slave rtcp_slave_chk u_chk (.core_clk, .sys_rst, .scl_in, .sda_in,
  .sda_out, .sda_oe, .wr_stb, .wr_addr, .wr_data, .rd_addr, .rd_data,
  .rd_stb, .busy, .selected);

// ==== tb/rtcp_master.sv ====
// Bus master model: drives the serial clock and its own data pull.
// Assumes sda is the wired level of all data drivers, pulled up.
`timescale 1ns/10ps

module rtcp_master (
  // Clock
  input  wire logic core_clk,
  // Bus
  input  wire logic sda,
  output logic      scl,
  output logic      sda_m
);
  initial begin
    scl = 1'b1;
    sda_m = 1'b1;
  end

  task automatic w(input int n);
    repeat (n) @(negedge core_clk);
  endtask

  // start from idle or low clock
  task automatic start();
    w(4);
    sda_m = 1'b1;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b0;
    w(8);
    scl = 1'b0;
  endtask

  task automatic stop();
    w(4);
    sda_m = 1'b0;
    w(4);
    scl = 1'b1;
    w(8);
    sda_m = 1'b1;
    w(8);
  endtask

  // nine pulses, top bit first
  // 400 ns per bit: 300 ns low, 100 ns high; the slave answers about
  // 225 ns after the falling clock, so the long low phase covers it
  task automatic xb(input logic [8:0] o, output logic [8:0] i);
    for (int k = 8; k >= 0; k--) begin
      w(1);
      sda_m = o[k];
      w(5);
      scl = 1'b1;
      w(1);
      i[k] = sda;
      w(1);
      scl = 1'b0;
    end
  endtask
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench of the slave port against a bus master model.
// Assumes a small register file here answers rd_addr combinationally.
`timescale 1ns/10ps

module testbench;
  import rtcp_pkg::*;
  logic          core_clk;
  logic          sys_rst;
  logic          scl;
  logic          sda;
  logic          sda_m;
  logic          sda_out;
  logic          sda_oe;
  logic          wr_stb;
  logic          rd_stb;
  logic          busy;
  logic          selected;
  rtcp_byte_type wr_addr;
  rtcp_byte_type wr_data;
  rtcp_byte_type rd_addr;
  rtcp_byte_type rd_data;
  logic [7:0]    mem [256];
  logic [8:0]    r;
  int            failures;
  int            checks_done;

  // Open drain with pull-up: low wins
  assign sda = sda_m & (sda_oe ? sda_out : 1'b1);
  assign rd_data = mem[rd_addr];

  rtcp_slave dut (.core_clk, .sys_rst, .scl_in(scl), .sda_in(sda), .sda_out,
    .sda_oe, .wr_stb, .wr_addr, .wr_data, .rd_addr, .rd_data, .rd_stb, .busy,
    .selected);
  rtcp_master m (.core_clk, .sda, .scl, .sda_m);

  initial begin
    core_clk = 1'b0;
    forever #25 core_clk = ~core_clk;
  end

  always @(posedge core_clk) begin
    if (wr_stb === 1'b1) mem[wr_addr] <= wr_data;
  end

  task automatic chk(input logic [7:0] s, input logic [7:0] e);
    checks_done++;
    if (s !== e) begin
      failures++;
      $display("Error at %0t ns: seen %h expected %h", $time, s, e);
    end
  endtask

  task automatic final_report();
    $display("Checks %0d, mismatches %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  task automatic t_reset();
    chk(sda_oe, 8'h00);
    chk(busy, 8'h00);
    chk(rd_addr, 8'h00);
  endtask

  // Pointer near the top so the data run wraps
  task automatic t_write();
    m.start();
    chk(busy, 8'h01);
    m.xb({8'hd0, 1'b1}, r);
    chk(r[0], 8'h00);
    m.xb({8'hfe, 1'b1}, r);
    chk(r[0], 8'h00);
    for (int i = 0; i < 3; i++) begin
      m.xb({8'hc0 + 8'(i), 1'b1}, r);
      chk(r[0], 8'h00);
    end
    chk(selected, 8'h01);
    m.stop();
    chk(busy, 8'h00);
    chk(mem[8'hfe], 8'hc0);
    chk(mem[8'hff], 8'hc1);
    chk(mem[8'h00], 8'hc2);
    chk(rd_addr, 8'h01);
  endtask

  task automatic t_read();
    m.start();
    m.xb({8'hd1, 1'b1}, r);
    chk(r[0], 8'h00);
    m.xb({8'hff, 1'b0}, r);
    chk(r[8:1], 8'h01 ^ 8'h5a);
    m.xb({8'hff, 1'b1}, r);
    chk(r[8:1], 8'h02 ^ 8'h5a);
    repeat (8) @(negedge core_clk);
    chk(sda_oe, 8'h00);
    m.stop();
    chk(rd_addr, 8'h03);
  endtask

  task automatic t_rep();
    m.start();
    m.xb({8'hd0, 1'b1}, r);
    m.xb({8'h10, 1'b1}, r);
    m.start();
    m.xb({8'hd1, 1'b1}, r);
    chk(r[0], 8'h00);
    m.xb({8'hff, 1'b1}, r);
    chk(r[8:1], 8'h10 ^ 8'h5a);
    m.stop();
  endtask

  // Off-by-one address must be ignored as well
  task automatic t_foreign();
    logic [7:0] adr [2];
    adr = '{8'ha0, 8'hd2};
    for (int i = 0; i < 2; i++) begin
      m.start();
      m.xb({adr[i], 1'b1}, r);
      chk(r[0], 8'h01);
      m.xb({8'h00, 1'b1}, r);
      chk(r[0], 8'h01);
      chk(selected, 8'h00);
      m.stop();
    end
  endtask

  initial begin
    failures = 0;
    checks_done = 0;
    sys_rst = 1'b1;
    for (int i = 0; i < 256; i++) mem[i] = 8'(i) ^ 8'h5a;
    repeat (8) @(negedge core_clk);
    sys_rst = 1'b0;
    repeat (8) @(negedge core_clk);
    t_reset();
    t_write();
    t_read();
    t_rep();
    t_foreign();
    final_report();
  end
endmodule
